/* verilog/irq_mask_pkg.sv */
// constants for the interrupt request and mask logic
// assumes a single 32-bit AHB-Lite slave, one register per word
`default_nettype none
package irq_mask_pkg;
    localparam int NUM_SOURCES = 6;
    // register indices; the byte address is four times the index
    localparam logic [7:0] ADDR_PRIORITY = 8'hF8;
    localparam logic [7:0] ADDR_PENDING = 8'hFA;
    localparam logic [7:0] ADDR_MASK = 8'hFB;
    localparam logic [7:0] ADDR_CORE_CTRL = 8'hFC;
    localparam logic [7:0] PENDING_RESET = 8'h00;
    localparam int EDGE_HI = 7;
    localparam int EDGE_LO = 6;
    localparam int MASTER_BIT = 7;
    localparam int RSVD_BIT = 6;
    localparam logic [1:0] EDGE_FF = 2'h0;
    localparam logic [1:0] EDGE_FR = 2'h1;
    localparam logic [1:0] EDGE_RF = 2'h2;
    localparam logic [1:0] EDGE_BOTH = 2'h3;
    // pending bit positions
    localparam int SRC_ZERO = 0;
    localparam int SRC_ONE = 1;
    localparam int SRC_FIRST_PIN = 2;
    localparam int SRC_T16 = 3;
    localparam int SRC_T8 = 4;
    localparam int SRC_LOW_VOLTAGE = 5;
    // core control register bits, write one to act
    localparam int CTRL_EI = 0;
    localparam int CTRL_DI = 1;
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [2:0] HSIZE_WORD = 3'h2;
endpackage : irq_mask_pkg
`default_nettype wire

/* verilog/interrupt_request_mask_logic.sv */
// six-source interrupt pending, edge select, mask and priority grant
// assumes pin inputs are asynchronous; core pulses are on i_ref_clk
`default_nettype none
module interrupt_request_mask_logic
    import irq_mask_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_hsel,
    input wire logic [31:0] i_haddr,
    input wire logic [1:0] i_htrans,
    input wire logic i_hwrite,
    input wire logic [2:0] i_hsize,
    input wire logic [31:0] i_hwdata,
    input wire logic i_hready,
    output logic [31:0] o_hrdata,
    output logic o_hreadyout,
    output logic o_hresp,
    input wire logic i_port_pin_first,
    input wire logic i_port_pin_second,
    input wire logic i_source_one_event,
    input wire logic i_sixteen_bit_timer,
    input wire logic i_eight_bit_timer,
    input wire logic i_low_voltage_source,
    input wire logic i_enable_interrupts_instr,
    input wire logic i_disable_interrupts_instr,
    input wire logic i_core_ack,
    output logic o_irq_req,
    output logic [NUM_SOURCES-1:0] o_grant_onehot
);
    logic [1:0] pin_meta_reg;
    logic [1:0] pin_sync_reg;
    logic [1:0] pin_prev_reg;
    logic [1:0] edge_sel_reg;
    logic [NUM_SOURCES-1:0] pending_reg;
    logic [NUM_SOURCES-1:0] pending_next;
    logic [NUM_SOURCES-1:0] enable_reg;
    logic master_reg;
    logic unlocked_reg;
    logic [5:0] priority_select_reg;
    logic wr_pend_reg;
    logic wr_mask_reg;
    logic wr_prio_reg;
    logic wr_ctrl_reg;
    logic rd_pend;
    logic rd_mask;
    logic rd_prio;
    logic [NUM_SOURCES-1:0] hw_set;
    logic [NUM_SOURCES-1:0] active;
    logic [NUM_SOURCES-1:0] grant;
    logic [1:0] rise;
    logic [1:0] fall;
    logic [1:0] pin_event;
    logic addr_ok;
    logic ei_ctrl;
    logic di_ctrl;
    logic take;

    // priority order: list of six source indices, highest first
    function automatic logic [NUM_SOURCES-1:0] pick(
        input logic [NUM_SOURCES-1:0] req,
        input logic [5:0] prio
    );
        int ord [6];
        int a_hi;
        int a_lo;
        int b_hi;
        int b_lo;
        int c_hi;
        int c_lo;
        logic [2:0] grp;
        logic [NUM_SOURCES-1:0] res;
        a_hi = prio[5] ? SRC_T16 : SRC_LOW_VOLTAGE;
        a_lo = prio[5] ? SRC_LOW_VOLTAGE : SRC_T16;
        b_hi = prio[2] ? SRC_ZERO : SRC_FIRST_PIN;
        b_lo = prio[2] ? SRC_FIRST_PIN : SRC_ZERO;
        c_hi = prio[1] ? SRC_T8 : SRC_ONE;
        c_lo = prio[1] ? SRC_ONE : SRC_T8;
        grp = {prio[4:3], prio[0]};
        // reserved group codes fall back to a > b > c
        case (grp)
            3'h1: ord = '{c_hi, c_lo, a_hi, a_lo, b_hi, b_lo};
            3'h3: ord = '{a_hi, a_lo, c_hi, c_lo, b_hi, b_lo};
            3'h4: ord = '{b_hi, b_lo, c_hi, c_lo, a_hi, a_lo};
            3'h5: ord = '{c_hi, c_lo, b_hi, b_lo, a_hi, a_lo};
            3'h6: ord = '{b_hi, b_lo, a_hi, a_lo, c_hi, c_lo};
            default: ord = '{a_hi, a_lo, b_hi, b_lo, c_hi, c_lo};
        endcase
        res = '0;
        for (int k = NUM_SOURCES - 1; k >= 0; k--) begin
            if (req[ord[k]]) begin
                res = '0;
                res[ord[k]] = 1'b1;
            end
        end
        return res;
    endfunction : pick

    // pins pass two flops before the edge detector looks at them
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            pin_meta_reg <= 2'h0;
            pin_sync_reg <= 2'h0;
            pin_prev_reg <= 2'h0;
        end else begin
            pin_meta_reg <= {i_port_pin_second, i_port_pin_first};
            pin_sync_reg <= pin_meta_reg;
            pin_prev_reg <= pin_sync_reg;
        end
    end

    assign rise = pin_sync_reg & ~pin_prev_reg;
    assign fall = ~pin_sync_reg & pin_prev_reg;

    always_comb begin
        case (edge_sel_reg)
            EDGE_FF: pin_event = fall;
            EDGE_FR: pin_event = {rise[1], fall[0]};
            EDGE_RF: pin_event = {fall[1], rise[0]};
            EDGE_BOTH: pin_event = rise | fall;
            default: pin_event = 2'h0;
        endcase
    end

    always_comb begin
        hw_set = '0;
        hw_set[SRC_ZERO] = pin_event[1];
        hw_set[SRC_ONE] = i_source_one_event;
        hw_set[SRC_FIRST_PIN] = pin_event[0];
        hw_set[SRC_T16] = i_sixteen_bit_timer;
        hw_set[SRC_T8] = i_eight_bit_timer;
        hw_set[SRC_LOW_VOLTAGE] = i_low_voltage_source;
    end

    assign active = pending_reg & enable_reg & {NUM_SOURCES{master_reg}};
    assign grant = pick(active, priority_select_reg);

    // address phase decode
    assign take = i_hsel && i_hready && i_htrans == HTRANS_NONSEQ;
    assign addr_ok = i_hsize == HSIZE_WORD && i_haddr[1:0] == 2'h0;
    // indices are not word multiples, so each sits at four times its index
    assign rd_pend = take && !i_hwrite && i_haddr[9:2] == ADDR_PENDING;
    assign rd_mask = take && !i_hwrite && i_haddr[9:2] == ADDR_MASK;
    assign rd_prio = take && !i_hwrite && i_haddr[9:2] == ADDR_PRIORITY;

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            wr_pend_reg <= 1'b0;
            wr_mask_reg <= 1'b0;
            wr_prio_reg <= 1'b0;
            wr_ctrl_reg <= 1'b0;
        end else if (i_hready) begin
            wr_pend_reg <= take && i_hwrite && addr_ok
                && i_haddr[9:2] == ADDR_PENDING;
            wr_mask_reg <= take && i_hwrite && addr_ok
                && i_haddr[9:2] == ADDR_MASK;
            wr_prio_reg <= take && i_hwrite && addr_ok
                && i_haddr[9:2] == ADDR_PRIORITY;
            wr_ctrl_reg <= take && i_hwrite && addr_ok
                && i_haddr[9:2] == ADDR_CORE_CTRL;
        end
    end

    // the byte addresses alias per word; registers hold the low byte
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_hrdata <= 32'h0000_0000;
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
        end else begin
            o_hreadyout <= 1'b1;
            o_hresp <= 1'b0;
            if (rd_pend) begin
                o_hrdata <= {24'h00_0000, edge_sel_reg, pending_reg};
            end else if (rd_mask) begin
                // reserved bit reads as zero
                o_hrdata <= {24'h00_0000, master_reg, 1'b0, enable_reg};
            end else if (rd_prio) begin
                o_hrdata <= {26'h000_0000, priority_select_reg};
            end else begin
                o_hrdata <= 32'h0000_0000;
            end
        end
    end

    assign ei_ctrl = wr_ctrl_reg && i_hwdata[CTRL_EI];
    assign di_ctrl = wr_ctrl_reg && i_hwdata[CTRL_DI];

    // hardware set beats a software clear in the same cycle
    always_comb begin
        pending_next = pending_reg;
        if (wr_pend_reg && unlocked_reg) begin
            pending_next = i_hwdata[NUM_SOURCES-1:0];
        end
        if (i_core_ack) begin
            pending_next = pending_next & ~grant;
        end
        pending_next = pending_next | hw_set;
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            pending_reg <= PENDING_RESET[NUM_SOURCES-1:0];
            edge_sel_reg <= PENDING_RESET[EDGE_HI:EDGE_LO];
        end else begin
            pending_reg <= pending_next;
            if (wr_pend_reg && unlocked_reg) begin
                edge_sel_reg <= i_hwdata[EDGE_HI:EDGE_LO];
            end
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            unlocked_reg <= 1'b0;
        end else if (i_enable_interrupts_instr || ei_ctrl) begin
            unlocked_reg <= 1'b1;
        end
    end

    // individual enables are not reset; bit 6 written by software is dropped
    always_ff @(posedge i_ref_clk) begin
        if (wr_mask_reg) begin
            enable_reg <= i_hwdata[NUM_SOURCES-1:0];
        end
        if (wr_prio_reg) begin
            priority_select_reg <= i_hwdata[5:0];
        end
    end

    // a mask write to bit 7 does not move the master enable
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            master_reg <= 1'b0;
        end else if (i_core_ack && |active) begin
            master_reg <= 1'b0;
        end else if (i_disable_interrupts_instr || di_ctrl) begin
            master_reg <= 1'b0;
        end else if (i_enable_interrupts_instr || ei_ctrl) begin
            master_reg <= 1'b1;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn) begin
            o_irq_req <= 1'b0;
            o_grant_onehot <= '0;
        end else begin
            o_irq_req <= |active;
            o_grant_onehot <= grant;
        end
    end
endmodule : interrupt_request_mask_logic
`default_nettype wire

/* test/irq_mask_props.sv */
// checker: request gating, grant shape and acknowledge effects
// assumes it is bound onto the request and mask block
`default_nettype none
module irq_mask_props
    import irq_mask_pkg::*;
(
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_core_ack,
    input wire logic i_disable_interrupts_instr,
    input wire logic o_irq_req,
    input wire logic [NUM_SOURCES-1:0] o_grant_onehot
);
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_resetn);
    property p_ack; i_core_ack |-> ##2 !o_irq_req; endproperty
    a_ack: assert property (p_ack)
        else $error("request after ack");
    property p_di; i_disable_interrupts_instr |-> ##2 !o_irq_req; endproperty
    a_di: assert property (p_di)
        else $error("request after disable");
    property p_rst; $rose(i_resetn) |-> !o_irq_req ##1 !o_irq_req; endproperty
    a_rst: assert property (p_rst)
        else $error("request out of reset");
    property p_hot; $onehot0(o_grant_onehot); endproperty
    a_hot: assert property (p_hot)
        else $error("grant not one-hot");
    property p_req; o_irq_req |-> o_grant_onehot != '0; endproperty
    a_req: assert property (p_req)
        else $error("request with no source");
    property p_clr;
        i_core_ack |-> ##2 (o_grant_onehot & $past(o_grant_onehot, 2)) == '0;
    endproperty
    a_clr: assert property (p_clr)
        else $error("serviced source still granted");
    property p_rack; $rose(o_irq_req) |-> !$past(i_core_ack, 2); endproperty
    a_rack: assert property (p_rack)
        else $error("request rose after ack");
    property p_rdi;
        $rose(o_irq_req) |-> !$past(i_disable_interrupts_instr, 2);
    endproperty
    a_rdi: assert property (p_rdi)
        else $error("request rose after disable");
    c_ack: cover property (i_core_ack);
    c_rise: cover property ($rose(o_irq_req));
    c_di: cover property (i_disable_interrupts_instr && o_irq_req);
endmodule : irq_mask_props
`default_nettype wire

/* test/core_model.sv */
// core stand-in: enable/disable pulses and a delayed acknowledge
// assumes request and pulses share i_ref_clk
`default_nettype none
module core_model (
    input wire logic i_ref_clk,
    input wire logic i_resetn,
    input wire logic i_irq_req,
    input wire logic i_ei_cmd,
    input wire logic i_di_cmd,
    input wire logic [3:0] i_lag,
    output logic o_ei,
    output logic o_di,
    output logic o_ack
);
    logic [3:0] wait_reg;
    // registered enable and disable pulses; an ack and core control writes also move the master enable
    always_ff @(posedge i_ref_clk) begin
        o_ei <= i_resetn & i_ei_cmd;
        o_di <= i_resetn & i_di_cmd;
    end
    // one ack per request for lag below 14; counter saturates at 14 so lag 15 never answers
    always_ff @(posedge i_ref_clk) begin
        if (!i_resetn || !i_irq_req) begin
            wait_reg <= 4'h0;
        end else if (wait_reg != 4'hE) begin
            wait_reg <= wait_reg + 4'h1;
        end
        o_ack <= i_resetn & i_irq_req & (wait_reg == i_lag);
    end
endmodule : core_model
`default_nettype wire

/* test/interrupt_request_mask_logic_tb_top.sv */
// bench: bus master tasks, core stand-in, reference register model
// assumes package, design, checker and core model compile first
`default_nettype none
module interrupt_request_mask_logic_tb_top
    import irq_mask_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0, rstn = 1'b0, sel = 1'b0, hw = 1'b0;
    logic pin1 = 1'b0, pin2 = 1'b0, ei_cmd = 1'b0, di_cmd = 1'b0;
    logic [31:0] addr = 32'h0, wdata = 32'h0, hrd, rd;
    logic [1:0] trans = 2'h0;
    logic [3:0] ev_reg = 4'h0, lag = 4'hF;
    logic [5:0] grant;
    logic rdy, resp, req, ei, di, ack;
    int seed = 32'h0000_3ecf, miscompares = 0, num_checks = 0;
    int pend = 0, msk = 0;
    int ord[6] = '{5, 3, 2, 0, 1, 4};
    always #4 clk = ~clk;
    interrupt_request_mask_logic interrupt_request_mask_logic_inst (
        .i_ref_clk(clk), .i_resetn(rstn), .i_hsel(sel), .i_haddr(addr),
        .i_htrans(trans), .i_hwrite(hw), .i_hsize(HSIZE_WORD),
        .i_hwdata(wdata), .i_hready(rdy), .o_hrdata(hrd),
        .o_hreadyout(rdy), .o_hresp(resp), .i_port_pin_first(pin1),
        .i_port_pin_second(pin2), .i_source_one_event(ev_reg[0]),
        .i_sixteen_bit_timer(ev_reg[1]), .i_eight_bit_timer(ev_reg[2]),
        .i_low_voltage_source(ev_reg[3]), .i_enable_interrupts_instr(ei),
        .i_disable_interrupts_instr(di), .i_core_ack(ack),
        .o_irq_req(req), .o_grant_onehot(grant));
    core_model core_model_inst (.i_ref_clk(clk), .i_resetn(rstn),
        .i_irq_req(req), .i_ei_cmd(ei_cmd), .i_di_cmd(di_cmd),
        .i_lag(lag), .o_ei(ei), .o_di(di), .o_ack(ack));
    task close_out;
        $display("checks %0d mismatches %0d", num_checks, miscompares);
        if (miscompares == 0 && num_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : close_out
    task chk(input logic [31:0] e, input logic [31:0] a);
        num_checks++;
        if (a !== e) begin
            miscompares++;
            $display("MISMATCH t=%0t exp=%h got=%h", $time, e, a);
        end
    endtask : chk
    // waits for bus ready or, with use_ack, for the core acknowledge
    task step(input logic use_ack);
        int n;
        n = 0;
        do begin
            @(posedge clk);
            n++;
        end while ((use_ack ? ack : rdy) !== 1'b1 && n < 64);
        if ((use_ack ? ack : rdy) !== 1'b1) begin
            miscompares++;
            close_out;
        end
    endtask : step
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
        sel <= 1'b1;
        trans <= HTRANS_NONSEQ;
        hw <= w;
        // register index to byte address
        addr <= {22'h00_0000, a, 2'h0};
        step(1'b0);
        sel <= 1'b0;
        trans <= 2'h0;
        wdata <= d;
        step(1'b0);
        rd = hrd;
    endtask : bus
    task put(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask : put
    task get(input logic [7:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        chk(e, rd);
    endtask : get
    task core(input logic en);
        ei_cmd <= en;
        di_cmd <= !en;
        @(posedge clk);
        ei_cmd <= 1'b0;
        di_cmd <= 1'b0;
        repeat (2) @(posedge clk);
    endtask : core
    initial begin
        repeat (20) @(posedge clk);
        rstn <= 1'b1;
        get(ADDR_PENDING, 32'h0);
        bus(1'b0, ADDR_MASK, 32'h0);
        chk(32'h0, rd & 32'hFFFF_FFC0);
        // order 5,3,2,0,1,4: group code 010 is A>B>C, in-group bits zero
        put(ADDR_PRIORITY, 32'h0000_0008);
        put(ADDR_PENDING, 32'h0000_003F);
        get(ADDR_PENDING, 32'h0);
        core(1'b0);
        put(ADDR_MASK, 32'h0000_00FF);
        get(ADDR_MASK, 32'h0000_003F);
        core(1'b1);
        get(ADDR_MASK, 32'h0000_00BF);
        repeat (8) begin
            core(1'b0);
            msk = $random(seed) & 8'h3F;
            put(ADDR_MASK, msk | 8'h40);
            core(1'b1);
            pend = $random(seed) & 8'hFF;
            put(ADDR_PENDING, pend);
            get(ADDR_PENDING, pend);
            chk((pend & msk) != 0, req);
        end
        for (int c = 0; c < 4; c++) begin
            put(ADDR_PENDING, c << 6);
            pin1 <= 1'b1;
            pin2 <= 1'b1;
            repeat (6) @(posedge clk);
            get(ADDR_PENDING, c << 6 | (c & 2) << 1 | c & 1);
            put(ADDR_PENDING, c << 6);
            pin1 <= 1'b0;
            pin2 <= 1'b0;
            repeat (6) @(posedge clk);
            get(ADDR_PENDING, c << 6 | (c != 2) * 4 | c != 1);
        end
        for (int i = 0; i < 4; i++) begin
            put(ADDR_PENDING, 32'h0);
            ev_reg <= 4'h1 << i;
            @(posedge clk);
            ev_reg <= 4'h0;
            get(ADDR_PENDING, 1 << (i == 0 ? 1 : i + 2));
        end
        core(1'b0);
        put(ADDR_MASK, 32'h0000_007F);
        pend = 8'h3F;
        put(ADDR_PENDING, pend);
        for (int k = 0; k < 6; k++) begin
            lag <= 4'($unsigned($random(seed)) % 7);
            core(1'b1);
            step(1'b1);
            chk(1 << ord[k], grant);
            pend = pend & ~(1 << ord[k]);
            get(ADDR_PENDING, pend);
            chk(32'h0, req);
        end
        core(1'b1);
        repeat (2) @(posedge clk);
        chk(32'h0, req);
        close_out;
    end
endmodule : interrupt_request_mask_logic_tb_top
bind interrupt_request_mask_logic irq_mask_props irq_mask_props_inst (
    .i_ref_clk(i_ref_clk), .i_resetn(i_resetn), .i_core_ack(i_core_ack),
    .i_disable_interrupts_instr(i_disable_interrupts_instr),
    .o_irq_req(o_irq_req), .o_grant_onehot(o_grant_onehot));
`default_nettype wire
